// >>> verilog/msa_target.sv
`timescale 1ns/1ps

// Function
// RULE1 - Address comes from three three-level strap pins
// RULE2 - Strap combinations decode into five low bits
// RULE3 - Top two address bits fixed to one, zero
// RULE4 - Broadcast address writes every device at once
// RULE5 - Broadcast ignored when its enable bit clear
// RULE6 - Alert response address answered during a fault
// RULE7 - Master uses only write byte, read byte
// RULE8 - Repeated start before stop discards the write
// RULE9 - Data byte commits to selected register at stop
// RULE10 - Two aux pins: input, open-drain or push-pull
// RULE11 - Direction bit per aux pin in control register
// RULE12 - Drive type bit picks open-drain or push-pull
// RULE13 - After alert response, return address, release alert
// RULE14 - Aux pin levels readable in aux register
// RULE15 - Register select from command byte low bits
// RULE16 - Broadcast only writes; alert response only reads
module msa_target import msa_pkg::*; (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic scl_i,
    input wire logic upstream_data_pin_i,
    output logic upstream_data_pin_o,
    output logic upstream_data_pin_oe_n_o,
    input wire logic [1:0] addr_strap_hi_i,
    input wire logic [1:0] addr_strap_mid_i,
    input wire logic [1:0] addr_strap_lo_i,
    input wire logic fault_event_i,
    output logic alert_oe_n_o,
    input wire logic aux_pin_one_i,
    output logic aux_pin_one_o,
    output logic aux_pin_one_oe_n_o,
    input wire logic aux_pin_two_i,
    output logic aux_pin_two_o,
    output logic aux_pin_two_oe_n_o,
    output logic [7:0] ctrl_reg0_o,
    output logic [7:0] ctrl_reg1_o,
    output logic [7:0] ctrl_reg2_o,
    output logic [7:0] ctrl_reg3_o
);

    msa_regs_s q_ff;
    msa_regs_s nxt_q;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic [6:0] own_addr;
    logic [1:0] aux_lvl;
    logic [7:0] rd_data;
    logic own_hit;
    logic bcast_hit;
    logic ara_hit;
    logic [1:0] aux_oe_n;
    logic [1:0] aux_val;

    // ------------------------------------------------------------
    // Strap decode
    // ------------------------------------------------------------
    function automatic logic [4:0] msa_strap_decode(input logic [1:0] hi,
                                                    input logic [1:0] mid,
                                                    input logic [1:0] lo);
        logic [1:0] m;
        logic [1:0] l;
        logic [4:0] base;
        logic [4:0] off;
        m = mid[1] ? LVL_OPEN : mid;
        l = lo[1] ? LVL_OPEN : lo;
        base = hi[1] ? 5'h08 : (hi[0] ? 5'h10 : 5'h00);
        off = 5'h00;
        case ({m, l})
            {LVL_OPEN, LVL_LOW}: off = 5'h00;
            {LVL_HIGH, LVL_OPEN}: off = 5'h01;
            {LVL_OPEN, LVL_OPEN}: off = 5'h02;
            {LVL_OPEN, LVL_HIGH}: off = 5'h03;
            {LVL_LOW, LVL_LOW}: off = 5'h04;
            {LVL_HIGH, LVL_HIGH}: off = 5'h05;
            {LVL_LOW, LVL_OPEN}: off = 5'h06;
            {LVL_LOW, LVL_HIGH}: off = 5'h07;
            default: off = 5'h00;
        endcase
        // The high/low pair of the two lower straps sits outside the regular grid
        if ({m, l} == {LVL_HIGH, LVL_LOW}) begin
            return hi[1] ? 5'h1A : (hi[0] ? 5'h18 : 5'h19);
        end
        return base + off;
    endfunction

    // ------------------------------------------------------------
    // Line conditions
    // ------------------------------------------------------------
    assign scl = q_ff.scl_s[1];
    assign sda = q_ff.sda_s[1];
    assign scl_rise = scl && !q_ff.scl_d;
    assign scl_fall = !scl && q_ff.scl_d;
    assign start_ev = scl && q_ff.scl_d && !sda && q_ff.sda_d;
    assign stop_ev = scl && q_ff.scl_d && sda && !q_ff.sda_d;
    assign aux_lvl = q_ff.aux_s[1];

    // Straps are static; decoding the synchronised copy live avoids a capture window
    assign own_addr = {ADDR_TOP, msa_strap_decode(q_ff.strap_s[1][5:4], // RULE3
                                                  q_ff.strap_s[1][3:2],
                                                  q_ff.strap_s[1][1:0])}; // RULE1 RULE2

    // Aux register reads back live pin levels in place of stored bits
    always_comb begin
        rd_data = q_ff.regs[q_ff.sel];
        if (q_ff.sel == REG_AUX) begin
            rd_data[AUX_LVL_LSB +: 2] = aux_lvl; // RULE14
        end
    end

    assign own_hit = q_ff.sh[7:1] == own_addr;
    assign bcast_hit = (q_ff.sh[7:1] == BCAST_ADDR) && !q_ff.sh[0] // RULE4 RULE16
        && q_ff.regs[REG_CTRL][CTRL_BCAST_BIT]; // RULE5
    assign ara_hit = (q_ff.sh[7:1] == ARA_ADDR) && q_ff.sh[0] && q_ff.alert; // RULE6 RULE16

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        nxt_q.scl_s = {q_ff.scl_s[0], scl_i};
        nxt_q.sda_s = {q_ff.sda_s[0], upstream_data_pin_i};
        nxt_q.scl_d = q_ff.scl_s[1];
        nxt_q.sda_d = q_ff.sda_s[1];
        nxt_q.aux_s = {q_ff.aux_s[0], {aux_pin_two_i, aux_pin_one_i}};
        nxt_q.strap_s = {q_ff.strap_s[0], {addr_strap_hi_i, addr_strap_mid_i, addr_strap_lo_i}};
        if (start_ev) begin
            // A repeated start drops any byte still waiting for its stop
            nxt_q.st = ST_ADDR; // RULE8
            nxt_q.bc = 4'h0;
            nxt_q.pend = 1'b0; // RULE8
            nxt_q.ara_tx = 1'b0;
            nxt_q.sda_oe_n = 1'b1;
        end else if (stop_ev) begin
            if (q_ff.pend) begin
                nxt_q.regs[q_ff.sel] = q_ff.dat; // RULE9
            end
            nxt_q.pend = 1'b0;
            nxt_q.st = ST_IDLE;
            nxt_q.sda_oe_n = 1'b1;
        end else begin
            unique case (q_ff.st)
                ST_IDLE: begin
                end
                ST_ADDR, ST_CMD, ST_DATA: begin
                    if (scl_rise) begin
                        nxt_q.sh = {q_ff.sh[6:0], sda};
                        nxt_q.bc = q_ff.bc + 4'h1;
                    end
                    if (scl_fall && q_ff.bc == BYTE_BITS) begin
                        nxt_q.bc = 4'h0;
                        if (q_ff.st == ST_ADDR) begin
                            // Own reads, own or broadcast writes, alert response reads
                            nxt_q.st = (own_hit || bcast_hit || ara_hit) ? ST_AACK : ST_IDLE;
                            nxt_q.sda_oe_n = !(own_hit || bcast_hit || ara_hit);
                            nxt_q.tx = ara_hit ? {own_addr, 1'b0} : rd_data; // RULE13
                            nxt_q.ara_tx = ara_hit && !own_hit;
                        end else if (q_ff.st == ST_CMD) begin
                            nxt_q.sel = q_ff.sh[1:0]; // RULE15
                            nxt_q.st = ST_CACK;
                            nxt_q.sda_oe_n = 1'b0;
                        end else begin
                            nxt_q.dat = q_ff.sh;
                            nxt_q.pend = 1'b1; // RULE7 RULE9
                            nxt_q.st = ST_DACK;
                            nxt_q.sda_oe_n = 1'b0;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        nxt_q.st = q_ff.sh[0] ? ST_TX : ST_CMD;
                        nxt_q.sda_oe_n = q_ff.sh[0] ? q_ff.tx[7] : 1'b1;
                    end
                end
                ST_CACK: begin
                    if (scl_fall) begin
                        nxt_q.st = ST_DATA;
                        nxt_q.sda_oe_n = 1'b1;
                    end
                end
                ST_DACK: begin
                    // Further bytes are not acknowledged; the stop still commits
                    if (scl_fall) begin
                        nxt_q.st = ST_IDLE;
                        nxt_q.sda_oe_n = 1'b1;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        nxt_q.bc = q_ff.bc + 4'h1;
                        // Released a one but the line reads low: another device won
                        if (q_ff.sda_oe_n && !sda) begin
                            nxt_q.st = ST_IDLE;
                            nxt_q.ara_tx = 1'b0;
                        end
                    end
                    if (scl_fall) begin
                        if (q_ff.bc == BYTE_BITS) begin
                            nxt_q.st = ST_MACK;
                            nxt_q.sda_oe_n = 1'b1;
                            if (q_ff.ara_tx) begin
                                nxt_q.alert = 1'b0; // RULE13
                            end
                            nxt_q.ara_tx = 1'b0;
                        end else begin
                            nxt_q.tx = {q_ff.tx[6:0], 1'b0};
                            nxt_q.sda_oe_n = q_ff.tx[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_fall) begin
                        nxt_q.st = ST_IDLE;
                    end
                end
                default: begin
                    nxt_q.st = ST_IDLE;
                    nxt_q.sda_oe_n = 1'b1;
                end
            endcase
        end
        // A new fault outranks the release in the same cycle
        if (fault_event_i) begin
            nxt_q.alert = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q_ff <= '0;
            q_ff.scl_s <= 2'h3;
            q_ff.sda_s <= 2'h3;
            q_ff.scl_d <= 1'b1;
            q_ff.sda_d <= 1'b1;
            q_ff.st <= ST_IDLE;
            q_ff.regs <= {RST_CONN, RST_CTRL, RST_AUX, RST_FAULT};
            q_ff.sda_oe_n <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ------------------------------------------------------------
    // Aux pins and outputs
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            aux_val[i] = q_ff.regs[REG_AUX][AUX_OUT_LSB + i];
            // Open-drain only pulls low; push-pull drives both levels
            aux_oe_n[i] = !(q_ff.regs[REG_CTRL][AUX_DIR_LSB + i] // RULE10 RULE11
                && (q_ff.regs[REG_CTRL][AUX_PP_LSB + i] || !aux_val[i])); // RULE12
        end
    end

    assign aux_pin_one_o = aux_val[0];
    assign aux_pin_two_o = aux_val[1];
    assign aux_pin_one_oe_n_o = aux_oe_n[0];
    assign aux_pin_two_oe_n_o = aux_oe_n[1];
    assign upstream_data_pin_o = 1'b0;
    assign upstream_data_pin_oe_n_o = q_ff.sda_oe_n;
    assign alert_oe_n_o = !q_ff.alert;
    assign ctrl_reg0_o = q_ff.regs[REG_FAULT];
    assign ctrl_reg1_o = q_ff.regs[REG_AUX];
    assign ctrl_reg2_o = q_ff.regs[REG_CTRL];
    assign ctrl_reg3_o = q_ff.regs[REG_CONN];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_addr_top_bits: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE3
        own_addr[6:5] == 2'h2) else $error("fixed address bits wrong");

    chk_strap_all_high: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE2
        q_ff.strap_s[1] == 6'h15 |-> own_addr == 7'h55) else $error("strap decode wrong");

    chk_bcast_masked: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE5
        (scl_fall && q_ff.st == ST_ADDR && q_ff.bc == BYTE_BITS
         && q_ff.sh == {BCAST_ADDR, 1'b0} && !q_ff.regs[REG_CTRL][CTRL_BCAST_BIT])
        |=> upstream_data_pin_oe_n_o && q_ff.st == ST_IDLE)
        else $error("masked broadcast acknowledged");

    chk_bcast_accept: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE4
        (scl_fall && q_ff.st == ST_ADDR && q_ff.bc == BYTE_BITS
         && q_ff.sh == {BCAST_ADDR, 1'b0} && q_ff.regs[REG_CTRL][CTRL_BCAST_BIT])
        |=> !upstream_data_pin_oe_n_o && q_ff.st == ST_AACK)
        else $error("broadcast write not acknowledged");

    chk_bcast_write_only: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE16
        (scl_fall && q_ff.st == ST_ADDR && q_ff.bc == BYTE_BITS
         && q_ff.sh == {BCAST_ADDR, 1'b1} && own_addr != BCAST_ADDR)
        |=> upstream_data_pin_oe_n_o) else $error("broadcast read acknowledged");

    chk_ara_ack: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE6
        (scl_fall && !start_ev && !stop_ev && q_ff.st == ST_ADDR && q_ff.bc == BYTE_BITS
         && q_ff.sh == {ARA_ADDR, 1'b1} && q_ff.alert)
        |=> !upstream_data_pin_oe_n_o && q_ff.st == ST_AACK)
        else $error("alert response not acknowledged");

    chk_rs_discard: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE8
        start_ev |=> !q_ff.pend ##1 $stable(q_ff.regs) || $past(stop_ev, 1))
        else $error("write kept across repeated start");

    chk_commit_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE9
        stop_ev && q_ff.pend |=> q_ff.regs[$past(q_ff.sel)] == $past(q_ff.dat) && !q_ff.pend)
        else $error("data not committed at stop");

    chk_only_at_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE9
        !stop_ev |=> $stable(q_ff.regs)) else $error("register changed without stop");

    chk_sel_from_cmd: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE15
        $rose(q_ff.st == ST_CACK) |-> q_ff.sel == q_ff.sh[1:0])
        else $error("select not from command byte");

    chk_aux_input: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE11
        !q_ff.regs[REG_CTRL][AUX_DIR_LSB] |-> aux_pin_one_oe_n_o)
        else $error("input aux pin driven");

    chk_aux_drive: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE12
        q_ff.regs[REG_CTRL][AUX_DIR_LSB + 1]
        |-> aux_pin_two_oe_n_o == (!q_ff.regs[REG_CTRL][AUX_PP_LSB + 1] && aux_pin_two_o))
        else $error("aux drive type wrong");

    chk_alert_release: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE13
        (q_ff.st == ST_TX && q_ff.ara_tx && scl_fall && !start_ev && !stop_ev
         && q_ff.bc == BYTE_BITS && !fault_event_i) |=> alert_oe_n_o)
        else $error("alert not released after response");

endmodule // msa_target

// >>> inc/msa_pkg.sv
package msa_pkg;

    // ------------------------------------------------------------
    // Strap level codes from the three-level sensing front end
    // ------------------------------------------------------------
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_HIGH = 2'h1;
    localparam logic [1:0] LVL_OPEN = 2'h2;

    // ------------------------------------------------------------
    // Target addresses
    // ------------------------------------------------------------
    localparam logic [1:0] ADDR_TOP = 2'h2;
    localparam logic [6:0] BCAST_ADDR = 7'h5D;
    localparam logic [6:0] ARA_ADDR = 7'h0C;

    // ------------------------------------------------------------
    // Register indices, field positions, reset values
    // ------------------------------------------------------------
    localparam logic [1:0] REG_FAULT = 2'h0;
    localparam logic [1:0] REG_AUX = 2'h1;
    localparam logic [1:0] REG_CTRL = 2'h2;
    localparam logic [1:0] REG_CONN = 2'h3;
    localparam int AUX_LVL_LSB = 0;
    localparam int AUX_OUT_LSB = 4;
    localparam int CTRL_BCAST_BIT = 3;
    localparam int AUX_PP_LSB = 4;
    localparam int AUX_DIR_LSB = 6;
    localparam logic [7:0] RST_FAULT = 8'h00;
    localparam logic [7:0] RST_AUX = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h08;
    localparam logic [7:0] RST_CONN = 8'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ------------------------------------------------------------
    // Bus state machine and block state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_AACK = 4'h2,
        ST_CMD = 4'h3,
        ST_CACK = 4'h4,
        ST_DATA = 4'h5,
        ST_DACK = 4'h6,
        ST_TX = 4'h7,
        ST_MACK = 4'h8
    } msa_state_e;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_d;
        logic sda_d;
        logic [1:0][1:0] aux_s;
        logic [1:0][5:0] strap_s;
        msa_state_e st;
        logic [7:0] sh;
        logic [3:0] bc;
        logic [1:0] sel;
        logic [7:0] dat;
        logic pend;
        logic [7:0] tx;
        logic ara_tx;
        logic [3:0][7:0] regs;
        logic alert;
        logic sda_oe_n;
    } msa_regs_s;

endpackage

// >>> tb/msa_master.sv
`timescale 1ns/1ps

module msa_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_n_o,
    output logic res_valid_o,
    output logic [10:0] res_o
);
    // Each bus phase lasts Q clocks, above the three the target needs to sync
    localparam int Q = 5;

    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
        res_valid_o = 1'b0;
        res_o = 11'h000;
    end

    // --------------------------------------------------------
    // Line phases
    // --------------------------------------------------------
    // Lines change just after an edge and hold for the whole phase
    task automatic pin(input logic c, input logic d);
        @(posedge clk_i);
        scl_o <= c;
        sda_oe_n_o <= d;
        repeat (Q - 1) @(posedge clk_i);
    endtask

    task automatic sbit(input logic b);
        pin(1'b0, b);
        pin(1'b1, b);
        pin(1'b1, b);
        pin(1'b0, b);
    endtask

    task automatic rbit(output logic b);
        pin(1'b0, 1'b1);
        pin(1'b1, 1'b1);
        b = sda_i;
        pin(1'b1, 1'b1);
        pin(1'b0, 1'b1);
    endtask

    task automatic sbyte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sbit(v[i]);
        end
        rbit(ack);
    endtask

    // Single byte reads always end with a not-acknowledge
    task automatic rbyte(output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            rbit(v[i]);
        end
        sbit(1'b1);
    endtask

    task automatic rstart();
        pin(1'b0, 1'b1);
        pin(1'b1, 1'b1);
        pin(1'b1, 1'b0);
        pin(1'b0, 1'b0);
    endtask

    // --------------------------------------------------------
    // Transactions
    // --------------------------------------------------------
    // Kind 0 write, 1 read, 2 alert response read, 3 write cut by a repeated start
    task automatic txn(input logic [1:0] k, input logic [6:0] a, input logic [7:0] c,
                       input logic [7:0] d);
        logic [2:0] ak;
        logic [7:0] rb;
        ak = 3'b111;
        rb = 8'h00;
        pin(1'b1, 1'b0);
        pin(1'b0, 1'b0);
        sbyte({a, k == 2'h2}, ak[2]);
        if (ak[2] == 1'b0 && k == 2'h2) begin
            rbyte(rb);
        end else if (ak[2] == 1'b0) begin
            sbyte(c, ak[1]);
            if (ak[1] == 1'b0 && k == 2'h1) begin
                rstart();
                sbyte({a, 1'b1}, ak[0]);
                if (ak[0] == 1'b0) rbyte(rb);
            end else if (ak[1] == 1'b0) begin
                sbyte(d, ak[0]);
                if (k == 2'h3) rstart();
            end
        end
        pin(1'b0, 1'b0);
        pin(1'b1, 1'b0);
        pin(1'b1, 1'b1);
        @(posedge clk_i);
        res_valid_o <= 1'b1;
        res_o <= {ak, rb};
        @(posedge clk_i);
        res_valid_o <= 1'b0;
    endtask
endmodule // msa_master

// >>> tb/msa_target_tb.sv
`timescale 1ns/1ps

`define MSA_CHK(act, exp, msg) \
    begin \
        cmp_count++; \
        if ((act) !== (exp)) begin \
            err_count++; \
            $display("[ERR] %0t %s got %h exp %h", $time, msg, act, exp); \
        end \
    end

module msa_target_tb import msa_pkg::*; ;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [1:0] hi = 2'h0, mid = 2'h0, lo = 2'h0;
    logic fault = 1'b0, x1 = 1'b1, x2 = 1'b1;
    logic scl, m_oe_n, d_o, d_oe_n, alert_n, res_v;
    logic a1_o, a1_oe_n, a2_o, a2_oe_n;
    logic [10:0] res, mon_exp;
    logic [7:0] ctl0, ctl1, ctl2, ctl3;
    logic [10:0] exp_q[$];
    logic [31:0] seed = 32'h0000A9B1;
    int err_count = 0;
    int cmp_count = 0;
    // Straps {hi, mid, lo} per address index, 0 low, 1 high, 2 open
    logic [5:0] tbl [27] = '{6'h08, 6'h06, 6'h0A, 6'h09, 6'h00, 6'h05, 6'h02, 6'h01,
        6'h28, 6'h26, 6'h2A, 6'h29, 6'h20, 6'h25, 6'h22, 6'h21, 6'h18, 6'h16,
        6'h1A, 6'h19, 6'h10, 6'h15, 6'h12, 6'h11, 6'h14, 6'h04, 6'h24};
    wire logic sda_w = m_oe_n & (d_oe_n | d_o);
    wire logic a1_w = a1_oe_n ? x1 : a1_o;
    wire logic a2_w = a2_oe_n ? x2 : a2_o;

    always #2.5 clk_i = ~clk_i;

    msa_target dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl),
        .upstream_data_pin_i(sda_w), .upstream_data_pin_o(d_o),
        .upstream_data_pin_oe_n_o(d_oe_n), .addr_strap_hi_i(hi), .addr_strap_mid_i(mid),
        .addr_strap_lo_i(lo), .fault_event_i(fault), .alert_oe_n_o(alert_n),
        .aux_pin_one_i(a1_w), .aux_pin_one_o(a1_o), .aux_pin_one_oe_n_o(a1_oe_n),
        .aux_pin_two_i(a2_w), .aux_pin_two_o(a2_o), .aux_pin_two_oe_n_o(a2_oe_n),
        .ctrl_reg0_o(ctl0), .ctrl_reg1_o(ctl1), .ctrl_reg2_o(ctl2), .ctrl_reg3_o(ctl3));

    msa_master m (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_n_o(m_oe_n),
        .res_valid_o(res_v), .res_o(res));

    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Open is sent as either spare code so both are exercised
    function automatic logic [1:0] lvl(input logic [1:0] c);
        logic [31:0] r;
        r = rnd();
        return (c == 2'h2) ? {1'b1, r[0]} : c;
    endfunction

    function automatic logic lv(input logic dir, input logic pp, input logic v, input logic x);
        return dir ? (pp ? v : (v & x)) : x;
    endfunction

    task automatic xfer(input logic [1:0] k, input logic [6:0] a, input logic [7:0] c,
                        input logic [7:0] d, input logic [10:0] e);
        exp_q.push_back(e);
        m.txn(k, a, c, d);
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // --------------------------------------------------------
    // Result monitor and watchdog
    // --------------------------------------------------------
    always @(posedge clk_i) begin
        if (res_v === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("[ERR] %0t result with nothing expected", $time);
            end else begin
                mon_exp = exp_q.pop_front();
                `MSA_CHK(res, mon_exp, "bus result")
            end
        end
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end

    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [6:0] own;
        logic [7:0] md, d;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        `MSA_CHK({ctl0, ctl1, ctl2, ctl3}, {RST_FAULT, RST_AUX, RST_CTRL, RST_CONN}, "reset regs")
        `MSA_CHK({d_oe_n, alert_n, a1_oe_n, a2_oe_n}, 4'hF, "reset drives")
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 27; i++) begin
            @(posedge clk_i);
            hi <= lvl(tbl[i][5:4]);
            mid <= lvl(tbl[i][3:2]);
            lo <= lvl(tbl[i][1:0]);
            own = {ADDR_TOP, i[4:0]};
            r = rnd();
            d = r[7:0];
            xfer(2'h0, own, {r[15:10], REG_CONN}, d, 11'h000);
            `MSA_CHK(ctl3, d, "strap write")
        end
        xfer(2'h0, own ^ 7'h60, {6'h00, REG_CONN}, ~d, 11'h700);
        `MSA_CHK(ctl3, d, "foreign address write")
        xfer(2'h1, own, 8'hFF, 8'h00, {3'b000, d});
        xfer(2'h1, own, {6'h00, REG_CTRL}, 8'h00, {3'b000, RST_CTRL});
        r = rnd();
        xfer(2'h0, BCAST_ADDR, {6'h00, REG_FAULT}, r[7:0], 11'h000);
        `MSA_CHK(ctl0, r[7:0], "broadcast write")
        xfer(2'h1, BCAST_ADDR, {6'h00, REG_FAULT}, 8'h00, 11'h100);
        xfer(2'h3, own, {6'h00, REG_FAULT}, ~r[7:0], 11'h000);
        `MSA_CHK(ctl0, r[7:0], "write cut by repeated start")
        xfer(2'h0, own, {6'h00, REG_CTRL}, 8'h00, 11'h000);
        xfer(2'h0, BCAST_ADDR, {6'h00, REG_FAULT}, ~r[7:0], 11'h700);
        `MSA_CHK({ctl2, ctl0}, {8'h00, r[7:0]}, "masked broadcast")
        for (int i = 0; i < 4; i++) begin
            md = (i == 0) ? 8'h00 : (i == 1) ? 8'hC0 : (i == 2) ? 8'hF0 : 8'hD0;
            r = rnd();
            @(posedge clk_i);
            x1 <= r[0];
            x2 <= r[1];
            xfer(2'h0, own, {6'h00, REG_AUX}, {2'h0, r[3:2], 4'h0}, 11'h000);
            xfer(2'h0, own, {6'h00, REG_CTRL}, md, 11'h000);
            `MSA_CHK({a1_oe_n, a2_oe_n}, {!(md[6] && (md[4] || !r[2])),
                !(md[7] && (md[5] || !r[3]))}, "aux drive")
            xfer(2'h1, own, {6'h00, REG_AUX}, 8'h00, {3'b000, 2'h0, r[3:2], 2'h0,
                lv(md[7], md[5], r[3], r[1]), lv(md[6], md[4], r[2], r[0])});
        end
        xfer(2'h2, ARA_ADDR, 8'h00, 8'h00, 11'h700);
        @(posedge clk_i);
        fault <= 1'b1;
        @(posedge clk_i);
        fault <= 1'b0;
        repeat (2) @(posedge clk_i);
        `MSA_CHK(alert_n, 1'b0, "alert raised")
        xfer(2'h0, ARA_ADDR, 8'h00, 8'h00, 11'h700);
        xfer(2'h2, ARA_ADDR, 8'h00, 8'h00, {3'b011, own, 1'b0});
        `MSA_CHK(alert_n, 1'b1, "alert released")
        tally_and_finish();
    end
endmodule // msa_target_tb
